// ### logic/rfac_defs.vh
// constants for the frequency-control and data-rate block
// assumes an 8-bit register port and a 100 MHz core clock
`ifndef RFAC_DEFS_VH
`define RFAC_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RFAC_A_TXRATE_HI 8'h6E
`define RFAC_A_TXRATE_LO 8'h6F
`define RFAC_A_TXSCALE 8'h70
`define RFAC_A_MODCTL2 8'h71
`define RFAC_A_DEV_LO 8'h72
`define RFAC_A_OFS_LO 8'h73
`define RFAC_A_OFS_HI 8'h74
`define RFAC_A_AFC_LIM 8'h2A
`define RFAC_A_AFC_CORR 8'h2B
`define RFAC_A_MODTUNE 8'h58
`define RFAC_A_AFC_CTL 8'h1D

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RFAC_R_TXRATE_HI 8'h0A
`define RFAC_R_TXRATE_LO 8'h3D
`define RFAC_R_TXSCALE 1'h0
`define RFAC_R_MODCTL2 8'h00
`define RFAC_R_DEV_LO 8'h20
`define RFAC_R_OFS 10'h000
`define RFAC_R_AFC_LIM 8'h00
`define RFAC_R_MODTUNE 8'h80
`define RFAC_R_AFC_CTL 8'h41

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RFAC_F_DEV_MSB 2
`define RFAC_F_TXSCALE 5
`define RFAC_F_AFC_EN 6
`define RFAC_F_MULTI_PKT 7
`define RFAC_F_GEAR_HI 5
`define RFAC_F_GEAR_LO 3
`define RFAC_F_CYC_HI 2
`define RFAC_F_CYC_LO 0

// ----------------------------------------------------------------
// scaling and timing
// ----------------------------------------------------------------
`define RFAC_DEV_STEP_HZ 19'd625
`define RFAC_MEAS_BITS 5'd2
`define RFAC_CLK_PERIOD_NS 10
`define RFAC_REF_PERIOD_NS 1000
`define RFAC_REF_DIV (`RFAC_REF_PERIOD_NS / `RFAC_CLK_PERIOD_NS)
// last count of the 1 MHz divider, one less than the divide ratio
`define RFAC_REF_LAST 7'h63
`define RFAC_RATE_SHIFT_BASE 16
`define RFAC_RATE_SHIFT_LOW 21
`define RFAC_CORR_MAX 8'h7F

`endif

// ### logic/rfac_bit_timer.v
// transmit bit-rate generator: phase accumulator on a 1 MHz tick
// assumes core_clk at 100 MHz and a synchronous active-low reset
`timescale 1ns/1ps
`include "rfac_defs.vh"

module rfac_bit_timer (
	input wire core_clk,
	input wire rst_n,
	input wire run,
	input wire [15:0] rate_word,
	input wire low_rate,
	output reg bit_tick
);

// ----------------------------------------------------------------
// 1 MHz reference tick
// ----------------------------------------------------------------
reg [6:0] ref_cnt;
wire ref_tick = (ref_cnt == `RFAC_REF_LAST);

always @(posedge core_clk) begin
	if (!rst_n || !run || ref_tick) begin
		ref_cnt <= 7'h00;
	end else begin
		ref_cnt <= ref_cnt + 7'h01;
	end
end

// ----------------------------------------------------------------
// accumulator; carry out of bit 16 or 21 gives one bit period
// ----------------------------------------------------------------
reg [21:0] phase;
wire [21:0] next_phase = phase + {6'h00, rate_word};
wire carry = low_rate ? next_phase[`RFAC_RATE_SHIFT_LOW]
	: next_phase[`RFAC_RATE_SHIFT_BASE];

always @(posedge core_clk) begin
	if (!rst_n || !run) begin
		phase <= 22'h000000;
		bit_tick <= 1'b0;
	end else if (ref_tick) begin
		// drop the carry bit so the phase wraps cleanly
		if (low_rate) begin
			phase <= {1'b0, next_phase[20:0]};
		end else begin
			phase <= {6'h00, next_phase[15:0]};
		end
		bit_tick <= carry;
	end else begin
		bit_tick <= 1'b0;
	end
end

endmodule

// ### logic/rfac_core.v
// frequency control: deviation, manual offset, receive AFC loop and
// transmit data-rate generator, with host registers on a plain port
// assumes one 100 MHz clock, synchronous active-low reset, and a
// demodulator that supplies bit ticks and a signed frequency error
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "rfac_defs.vh"

module rfac_core (
	input wire core_clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire tx_mode,
	input wire rx_mode,
	input wire band_high,
	input wire rx_bit_tick,
	input wire signed [9:0] freq_err,
	input wire preamble_det,
	input wire packet_end,
	output reg [8:0] deviation_code,
	output reg [18:0] deviation_hz,
	output reg signed [10:0] lo_offset_steps,
	output reg afc_frozen,
	output wire tx_bit_tick,
	output reg [7:0] tx_mod_tune
);

// ----------------------------------------------------------------
// host registers
// ----------------------------------------------------------------
reg [7:0] tx_bit_rate_high;
reg [7:0] tx_bit_rate_low;
reg tx_low_rate;
reg [7:0] modulation_control_two;
reg [7:0] deviation_low;
reg [9:0] offset_code;
reg [7:0] afc_pull_limit;
reg [7:0] afc_control;
reg signed [9:0] afc_corr;

wire afc_en = afc_control[`RFAC_F_AFC_EN];
wire multi_pkt = afc_control[`RFAC_F_MULTI_PKT];
wire [2:0] gear = afc_control[`RFAC_F_GEAR_HI:`RFAC_F_GEAR_LO];
wire [2:0] cycle = afc_control[`RFAC_F_CYC_HI:`RFAC_F_CYC_LO];

always @(posedge core_clk) begin
	if (!rst_n) begin
		tx_bit_rate_high <= `RFAC_R_TXRATE_HI;
		tx_bit_rate_low <= `RFAC_R_TXRATE_LO;
		tx_low_rate <= `RFAC_R_TXSCALE;
		modulation_control_two <= `RFAC_R_MODCTL2;
		deviation_low <= `RFAC_R_DEV_LO;
		offset_code <= `RFAC_R_OFS;
		afc_pull_limit <= `RFAC_R_AFC_LIM;
		afc_control <= `RFAC_R_AFC_CTL;
		tx_mod_tune <= `RFAC_R_MODTUNE;
	end else if (reg_wr) begin
		case (reg_addr)
		`RFAC_A_TXRATE_HI: begin
			tx_bit_rate_high <= reg_wdata;
		end
		`RFAC_A_TXRATE_LO: begin
			tx_bit_rate_low <= reg_wdata;
		end
		`RFAC_A_TXSCALE: begin
			tx_low_rate <= reg_wdata[`RFAC_F_TXSCALE];
		end
		`RFAC_A_MODCTL2: begin
			modulation_control_two <= reg_wdata;
		end
		`RFAC_A_DEV_LO: begin
			deviation_low <= reg_wdata;
		end
		`RFAC_A_OFS_LO: begin
			// offset_code is kept apart from afc_corr; manual writes only land with AFC off
			if (!afc_en) begin
				offset_code[7:0] <= reg_wdata;
			end
		end
		`RFAC_A_OFS_HI: begin
			if (!afc_en) begin
				offset_code[9:8] <= reg_wdata[1:0];
			end
		end
		`RFAC_A_AFC_LIM: begin
			afc_pull_limit <= reg_wdata;
		end
		`RFAC_A_AFC_CTL: begin
			afc_control <= reg_wdata;
		end
		`RFAC_A_MODTUNE: begin
			tx_mod_tune <= reg_wdata;
		end
		default: begin
			tx_low_rate <= tx_low_rate;
		end
		endcase
	end
end

// ----------------------------------------------------------------
// read port, data in the cycle after the strobe
// ----------------------------------------------------------------
reg [7:0] next_rdata;

always @* begin
	case (reg_addr)
	`RFAC_A_TXRATE_HI: next_rdata = tx_bit_rate_high;
	`RFAC_A_TXRATE_LO: next_rdata = tx_bit_rate_low;
	`RFAC_A_TXSCALE: next_rdata = {2'h0, tx_low_rate, 5'h00};
	`RFAC_A_MODCTL2: next_rdata = modulation_control_two;
	`RFAC_A_DEV_LO: next_rdata = deviation_low;
	`RFAC_A_OFS_LO: next_rdata = offset_code[7:0];
	`RFAC_A_OFS_HI: next_rdata = {6'h00, offset_code[9:8]};
	`RFAC_A_AFC_LIM: next_rdata = afc_pull_limit;
	`RFAC_A_AFC_CORR: next_rdata = afc_corr[7:0];
	`RFAC_A_AFC_CTL: next_rdata = afc_control;
	`RFAC_A_MODTUNE: next_rdata = tx_mod_tune;
	default: next_rdata = 8'h00;
	endcase
end

always @(posedge core_clk) begin
	if (!rst_n) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		reg_rdata <= next_rdata;
	end else begin
		reg_rdata <= 8'h00;
	end
end

// ----------------------------------------------------------------
// peak deviation, band independent
// ----------------------------------------------------------------
wire [8:0] next_dev_code =
	{modulation_control_two[`RFAC_F_DEV_MSB], deviation_low};

always @(posedge core_clk) begin
	if (!rst_n) begin
		deviation_code <= 9'h000;
		deviation_hz <= 19'h00000;
	end else begin
		deviation_code <= next_dev_code;
		deviation_hz <= {10'h000, next_dev_code} * `RFAC_DEV_STEP_HZ;
	end
end

// ----------------------------------------------------------------
// AFC loop states
// ----------------------------------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_MEAS = 2'b01;
localparam ST_CORR = 2'b10;
localparam ST_SETTLE = 2'b11;

reg [1:0] state;
reg [1:0] next_state;
reg [4:0] bit_cnt;
reg signed [10:0] err_sum;

// settle bits: cycle length 4 bits per cycle step, less the measure
wire [4:0] settle_bits = {cycle, 2'b00} - `RFAC_MEAS_BITS;
wire loop_on = afc_en && rx_mode && !afc_frozen && (cycle != 3'h0);

// averaged error, geared down, added and clamped to the limiter
wire signed [9:0] err_avg = err_sum[10:1];
wire signed [9:0] err_fb = err_avg >>> gear;
wire signed [10:0] corr_sum = {afc_corr[9], afc_corr} +
	{err_fb[9], err_fb};
wire [7:0] lim_mag = (afc_pull_limit > `RFAC_CORR_MAX) ?
	`RFAC_CORR_MAX : afc_pull_limit;
wire signed [10:0] lim_pos = {3'h0, lim_mag};
wire signed [10:0] lim_neg = -lim_pos;
reg signed [9:0] next_corr;

always @* begin
	if (corr_sum > lim_pos) begin
		next_corr = lim_pos[9:0];
	end else if (corr_sum < lim_neg) begin
		next_corr = lim_neg[9:0];
	end else begin
		next_corr = corr_sum[9:0];
	end
end

always @* begin
	next_state = state;
	case (state)
	ST_IDLE: begin
		if (loop_on) begin
			next_state = ST_MEAS;
		end
	end
	ST_MEAS: begin
		if (!loop_on) begin
			next_state = ST_IDLE;
		end else if (rx_bit_tick && bit_cnt == `RFAC_MEAS_BITS - 5'd1) begin
			next_state = ST_CORR;
		end
	end
	ST_CORR: begin
		next_state = loop_on ? ST_SETTLE : ST_IDLE;
	end
	ST_SETTLE: begin
		if (!loop_on) begin
			next_state = ST_IDLE;
		end else if (rx_bit_tick && bit_cnt == settle_bits - 5'd1) begin
			next_state = ST_MEAS;
		end
	end
	default: begin
		next_state = ST_IDLE;
	end
	endcase
end

always @(posedge core_clk) begin
	if (!rst_n) begin
		state <= ST_IDLE;
		bit_cnt <= 5'h00;
		err_sum <= 11'h000;
	end else begin
		state <= next_state;
		if (next_state != state) begin
			bit_cnt <= 5'h00;
		end else if (rx_bit_tick) begin
			bit_cnt <= bit_cnt + 5'h01;
		end
		if (state != ST_MEAS) begin
			err_sum <= 11'h000;
		end else if (rx_bit_tick) begin
			err_sum <= err_sum + {freq_err[9], freq_err};
		end
	end
end

// ----------------------------------------------------------------
// correction value, freeze and per-packet reset
// ----------------------------------------------------------------
reg signed [9:0] next_afc_corr;
reg next_frozen;

always @* begin
	next_afc_corr = afc_corr;
	next_frozen = afc_frozen;
	if (!afc_en || !rx_mode) begin
		next_afc_corr = 10'h000;
		next_frozen = 1'b0;
	end else if (packet_end) begin
		// packet end beats a preamble in the same cycle
		next_frozen = 1'b0;
		if (multi_pkt) begin
			next_afc_corr = 10'h000;
		end
	end else if (preamble_det) begin
		// freezing beats a correction in the same cycle
		next_frozen = 1'b1;
	end else if (state == ST_CORR && !afc_frozen) begin
		next_afc_corr = next_corr;
	end
end

always @(posedge core_clk) begin
	if (!rst_n) begin
		afc_corr <= 10'h000;
		afc_frozen <= 1'b0;
	end else begin
		afc_corr <= next_afc_corr;
		afc_frozen <= next_frozen;
	end
end

// ----------------------------------------------------------------
// local oscillator shift in 156.25 Hz units
// ----------------------------------------------------------------
wire use_afc = afc_en && rx_mode && !tx_mode;
wire signed [9:0] sel_code = use_afc ? afc_corr : offset_code;
wire signed [10:0] sel_ext = {sel_code[9], sel_code};
reg signed [10:0] next_lo_offset;

// high band doubles the step, low band keeps it
always @* begin
	case (band_high)
	1'b1: begin
		next_lo_offset = sel_ext <<< 1;
	end
	default: begin
		next_lo_offset = sel_ext;
	end
	endcase
end

always @(posedge core_clk) begin
	if (!rst_n) begin
		lo_offset_steps <= 11'h000;
	end else begin
		lo_offset_steps <= next_lo_offset;
	end
end

// ----------------------------------------------------------------
// transmit bit-rate generator
// ----------------------------------------------------------------
// rate word is live at once; the two bytes are not staged
wire [15:0] tx_rate_word = {tx_bit_rate_high, tx_bit_rate_low};

rfac_bit_timer u_bit_timer (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.run(tx_mode),
	.rate_word(tx_rate_word),
	.low_rate(tx_low_rate),
	.bit_tick(tx_bit_tick)
);

endmodule

// ### tb/rfac_core_chk.sv
// port assertions for the frequency-control block
// assumes a bind onto rfac_core and a single clock domain
`timescale 1ns/1ps
module rfac_core_chk (
	input logic core_clk,
	input logic rst_n,
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [7:0] reg_rdata,
	input logic tx_mode,
	input logic rx_mode,
	input logic band_high,
	input logic preamble_det,
	input logic packet_end,
	input logic [8:0] deviation_code,
	input logic [18:0] deviation_hz,
	input logic signed [10:0] lo_offset_steps,
	input logic afc_frozen,
	input logic tx_bit_tick
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence dev_wr;
		reg_wr && reg_addr == 8'h72;
	endsequence
	sequence frz_hold;
		afc_frozen && $past(afc_frozen) && rx_mode && !tx_mode;
	endsequence
	dev_hz_a: assert property (deviation_hz == deviation_code * 19'h271)
		else $error("deviation in hz does not follow the code");
	dev_wr_a: assert property (dev_wr |-> ##2 deviation_code[7:0] == $past(reg_wdata, 2))
		else $error("deviation low byte not taken");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	frz_set_a: assert property (preamble_det && !packet_end && rx_mode |=> afc_frozen)
		else $error("preamble did not freeze the loop");
	frz_clr_a: assert property (packet_end |=> !afc_frozen)
		else $error("packet end did not release the loop");
	frz_hold_a: assert property (frz_hold and $stable(band_high) |-> $stable(lo_offset_steps))
		else $error("offset moved while frozen");
	tx_idle_a: assert property (!tx_mode && !$past(tx_mode) |-> !tx_bit_tick)
		else $error("bit tick outside transmit");
	tx_pulse_a: assert property (tx_bit_tick |=> !tx_bit_tick [*8])
		else $error("bit ticks too close");
endmodule

// ### tb/rfac_demod_model.sv
// demodulator stand-in: bit ticks and a measured frequency error
// assumes the core clock; one tick every PERIOD cycles while enabled
`timescale 1ns/1ps
module rfac_demod_model #(
	parameter PERIOD = 8
) (
	input wire core_clk,
	input wire en,
	input wire [9:0] err_val,
	output reg rx_bit_tick,
	output reg [9:0] freq_err
);
	// ----------------------------------------------------------------
	// tick and error generation
	// ----------------------------------------------------------------
	integer cnt = 0;
	initial begin
		rx_bit_tick = 1'b0;
		freq_err = 10'h000;
	end
	always @(posedge core_clk) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		rx_bit_tick <= en && cnt == 0;
		// error is valid only beside a tick, otherwise it wanders
		freq_err <= (en && cnt == 0) ? err_val : ~freq_err;
	end
endmodule

// ### tb/radio_freq_afc_datarate_ctrl_tb_top.sv
// self-checking bench for the frequency-control block
// assumes the demodulator model and the bound checker
`timescale 1ns/1ps
module radio_freq_afc_datarate_ctrl_tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tx_mode = 1'b0;
	logic rx_mode = 1'b0;
	logic band_high = 1'b0;
	logic preamble_det = 1'b0;
	logic packet_end = 1'b0;
	logic en = 1'b0;
	logic [9:0] err_val = 10'h000;
	wire rx_bit_tick;
	wire tx_bit_tick;
	wire afc_frozen;
	wire [9:0] freq_err;
	wire [7:0] reg_rdata;
	wire [7:0] tx_mod_tune;
	wire [8:0] deviation_code;
	wire [18:0] deviation_hz;
	wire signed [10:0] lo_offset_steps;
	logic [7:0] rv;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	int n;
	logic [7:0] ra [7] = '{8'h6E, 8'h6F, 8'h71, 8'h72, 8'h73, 8'h74, 8'h58};
	logic [7:0] re [7] = '{8'h0A, 8'h3D, 8'h00, 8'h20, 8'h00, 8'h00, 8'h80};
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	rfac_core DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .tx_mode, .rx_mode, .band_high, .rx_bit_tick,
		.freq_err, .preamble_det, .packet_end, .deviation_code,
		.deviation_hz, .lo_offset_steps, .afc_frozen, .tx_bit_tick,
		.tx_mod_tune);
	rfac_demod_model PARTNER (.core_clk, .en, .err_val, .rx_bit_tick,
		.freq_err);
	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [18:0] s, input logic [18:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		// data stand for the one cycle after the strobe
		@(negedge core_clk);
		rv = reg_rdata;
		@(posedge core_clk);
	endtask
	// polls the correction readback until the loop has acted
	task poll;
		n = 0;
		do begin
			rd(8'h2B);
			n++;
		end while (rv === 8'h00 && n < 100);
	endtask
	task pulse(input int which);
		@(posedge core_clk);
		if (which == 0)
			preamble_det <= 1'b1;
		else
			packet_end <= 1'b1;
		@(posedge core_clk);
		preamble_det <= 1'b0;
		packet_end <= 1'b0;
	endtask
	// measures the clocks between two transmit bit ticks
	task gap(output int g);
		g = 0;
		do begin
			@(posedge core_clk);
			#1;
		end while (!tx_bit_tick);
		do begin
			@(posedge core_clk);
			#1;
			g++;
		end while (!tx_bit_tick);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			err_count++;
			print_verdict;
		end
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(ra[i]);
			chk("reset", rv, re[i]);
		end
		chk("devreset", deviation_hz, 19'h04E20);
		rd(8'h00);
		chk("unmapped", rv, 8'h00);
		$display("test reset done");
		wr(8'h71, 8'h04);
		wr(8'h72, 8'hFF);
		repeat (2) @(posedge core_clk);
		#1 chk("devhz", deviation_hz, 19'h1FF * 19'h271);
		chk("devcode", deviation_code, 9'h1FF);
		$display("test deviation done");
		wr(8'h1D, 8'h01);
		wr(8'h73, 8'h60);
		wr(8'h74, 8'h03);
		tx_mode <= 1'b1;
		band_high <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk("ofstx", lo_offset_steps, 11'sh6C0);
		@(posedge core_clk);
		tx_mode <= 1'b0;
		rx_mode <= 1'b1;
		band_high <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 chk("ofsrx", lo_offset_steps, 11'sh760);
		@(posedge core_clk);
		rx_mode <= 1'b0;
		wr(8'h1D, 8'h41);
		wr(8'h73, 8'h11);
		rd(8'h73);
		chk("lock", rv, 8'h60);
		$display("test offset done");
		wr(8'h2A, 8'h10);
		err_val <= 10'h028;
		en <= 1'b1;
		rx_mode <= 1'b1;
		poll;
		chk("clamp", rv, 8'h10);
		chk("afclo", lo_offset_steps, 11'sh010);
		rx_mode <= 1'b0;
		wr(8'h2A, 8'h7F);
		wr(8'h1D, 8'h49);
		rx_mode <= 1'b1;
		poll;
		chk("gear", rv, 8'h14);
		pulse(0);
		err_val <= 10'h3D8;
		repeat (200) @(posedge core_clk);
		rd(8'h2B);
		chk("frozen", rv, 8'h14);
		chk("frzflag", afc_frozen, 1'b1);
		wr(8'h1D, 8'hC9);
		pulse(1);
		rd(8'h2B);
		chk("pktreset", rv, 8'h00);
		rx_mode <= 1'b0;
		wr(8'h1D, 8'h40);
		rx_mode <= 1'b1;
		repeat (200) @(posedge core_clk);
		rd(8'h2B);
		chk("nocycle", rv, 8'h00);
		rx_mode <= 1'b0;
		en <= 1'b0;
		$display("test afc done");
		wr(8'h58, 8'hC0);
		repeat (2) @(posedge core_clk);
		#1 chk("tune", tx_mod_tune, 8'hC0);
		wr(8'h6E, 8'h80);
		wr(8'h6F, 8'h00);
		tx_mode <= 1'b1;
		gap(n);
		chk("rate", n[18:0], 19'h000C8);
		wr(8'h70, 8'h20);
		gap(n);
		gap(n);
		chk("slowrate", n[18:0], 19'h01900);
		@(posedge core_clk);
		tx_mode <= 1'b0;
		$display("test rate done");
		print_verdict;
	end
endmodule
bind rfac_core rfac_core_chk u_chk (.core_clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_mode, .rx_mode,
	.band_high, .preamble_det, .packet_end, .deviation_code,
	.deviation_hz, .lo_offset_steps, .afc_frozen, .tx_bit_tick);
